// ---- rtl/framer_pkg.sv ----
// constants, field layouts and carrier types for the framer control block
//
// Contract
// - top sixteen sync-word bits kept in a register, sent lsb first
// - in transmit, fifo flag asserts at or below almost-empty threshold
// - in receive, fifo flag asserts at or above almost-full threshold
// - receive starts when sync-bit errors are at most tolerance minus one
// - crc enable bit turns crc on, seeded from the eight-bit initial value
// - scramble enable bit whitens transmit data and restores receive data
// - length-byte enable makes the first payload byte the packet length
// - auto termination ends transmit when write index equals read index
// - auto-ack sends an acknowledge after a good receive, else go idle
// - polarity bit one drives packet and fifo flags active low
// - pattern-detected status sets on sync in receive, zero outside receive
// - host read of the data port pops, host write pushes
// - the data port moves one byte per access, other registers sixteen bits
// - write index clear zeroes the write index, ignored while receiving
// - read index clear zeroes the read index, ignored while transmitting
// - six-bit read-only write and read indexes are readable
// - whitening seed is nonzero and equal at both ends of the link
// - with auto-ack, a failed transmit is retried up to the limit, three
package framer_pkg;

  localparam int ADDR_W     = 7;
  localparam int WORD_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int PTR_W      = 6;
  localparam int CNT_W      = 5;
  localparam int SERR_W     = 7;
  localparam int CMD_BITS   = 8;
  localparam int DUMMY_BITS = 8;

  localparam logic [ADDR_W-1:0] ADDR_SYNC_TOP = 7'h27;
  localparam logic [ADDR_W-1:0] ADDR_THR      = 7'h28;
  localparam logic [ADDR_W-1:0] ADDR_OPT      = 7'h29;
  localparam logic [ADDR_W-1:0] ADDR_STAT     = 7'h30;
  localparam logic [ADDR_W-1:0] ADDR_FIFO     = 7'h32;
  localparam logic [ADDR_W-1:0] ADDR_PTR      = 7'h34;

  localparam logic [WORD_W-1:0] THR_RST      = 16'h2107;
  localparam logic [WORD_W-1:0] OPT_RST      = 16'hB800;
  localparam logic [WORD_W-1:0] SYNC_TOP_RST = 16'h0000;

  localparam int PTR_CLR_WR = 15;
  localparam int PTR_CLR_RD = 7;
  localparam logic [3:0] RETRY_DEFAULT = 4'h3;

  typedef struct packed {
    logic [4:0] empty_thr;
    logic [4:0] full_thr;
    logic [5:0] sync_tol;
  } thr_cfg_t;

  typedef struct packed {
    logic       crc_en;
    logic       scramble_en;
    logic       length_byte_enable;
    logic       auto_tx_termination;
    logic       auto_ack;
    logic       flag_output_polarity;
    logic [1:0] rsvd;
    logic [7:0] crc_seed;
  } opt_cfg_t;

  typedef struct packed {
    logic             tx_active;
    logic             rx_active;
    logic [5:0]       framer_state;
    logic             crc_error;
    logic             code_correction_fail;
    logic             packet_event;
    logic             rx_pkt_ok;
    logic             sync_candidate;
    logic [SERR_W-1:0] sync_errors;
  } eng_stat_t;

  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } host_req_t;

  typedef enum logic [1:0] {
    SPI_CMD  = 2'b00,
    SPI_WAIT = 2'b01,
    SPI_DATA = 2'b10,
    SPI_DONE = 2'b11
  } spi_st_t;

endpackage

// ---- rtl/radio_framer_fifo_ctrl.sv ----
// framer register file, spi slave, staging fifo and 64-byte data buffer
`timescale 1ns/1ps

module fifo_buf #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // depth must be a power of two so the indexes wrap on their own
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_r + AW'(push);
      rp_r  <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module radio_framer_fifo_ctrl
  import framer_pkg::*;
#(
  parameter logic [3:0] RETRY_LIMIT = 4'h3,
  parameter int         STG_DEPTH   = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  spi_sck,
  input  wire logic                  spi_ss_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso_out,
  output logic                       spi_miso_oe_n,
  input  wire framer_pkg::eng_stat_t eng_stat,
  output framer_pkg::thr_cfg_t       thr_cfg,
  output framer_pkg::opt_cfg_t       opt_cfg,
  output logic [15:0]                sync_word_top,
  input  wire logic                  sync_load,
  input  wire logic                  sync_advance,
  output logic                       sync_tx_bit,
  output logic                       rx_sync_start,
  output logic                       pattern_detected,
  output logic                       tx_terminate,
  output logic                       ack_request,
  output logic                       idle_request,
  output logic [3:0]                 retry_limit,
  input  wire logic                  rx_byte_valid,
  output logic                       rx_byte_ready,
  input  wire logic [7:0]            rx_byte,
  output logic                       tx_byte_valid,
  input  wire logic                  tx_byte_ready,
  output logic [7:0]                 tx_byte,
  output logic                       packet_flag_pin,
  output logic                       fifo_flag_pin
);
  import framer_pkg::*;

  // ---------------- spi side, runs on the host clock ----------------
  spi_st_t            st_r;
  spi_st_t            st_nxt;
  logic [CNT_W-1:0]   bit_cnt_r;
  logic [CNT_W-1:0]   bit_cnt_nxt;
  logic [WORD_W-1:0]  sh_in_r;
  logic [WORD_W-1:0]  sh_out_r;
  logic [CMD_BITS-1:0] cmd_r;
  logic               req_tgl_r;
  host_req_t          req_hold_r;
  logic               rst_link_r;
  logic [WORD_W-1:0]  rd_word_r;

  wire [CMD_BITS-1:0] cmd_now   = {sh_in_r[CMD_BITS-2:0], spi_mosi};
  wire                cmd_is_fifo = (cmd_r[ADDR_W-1:0] == ADDR_FIFO);
  wire [CNT_W-1:0]    data_len  = cmd_is_fifo ? CNT_W'(BYTE_W)
                                              : CNT_W'(WORD_W);
  wire                cmd_last  = (st_r == SPI_CMD) &&
                                  (bit_cnt_r == CNT_W'(CMD_BITS - 1));
  wire                wait_last = (st_r == SPI_WAIT) &&
                                  (bit_cnt_r == CNT_W'(DUMMY_BITS - 1));
  wire                data_last = (st_r == SPI_DATA) &&
                                  (bit_cnt_r == data_len - CNT_W'(1));
  wire                rd_fire   = cmd_last & cmd_now[CMD_BITS-1];
  wire                wr_fire   = data_last & ~cmd_r[CMD_BITS-1];
  // one byte per data-port access, a full word elsewhere
  wire [WORD_W-1:0]   wr_word   = cmd_is_fifo ?
                        {{BYTE_W{1'b0}}, sh_in_r[BYTE_W-2:0], spi_mosi} :
                        {sh_in_r[WORD_W-2:0], spi_mosi};
  wire                rd_load   = (st_r == SPI_DATA) && (bit_cnt_r == '0) &&
                                  cmd_r[CMD_BITS-1];

  always_comb begin
    st_nxt      = st_r;
    bit_cnt_nxt = bit_cnt_r + CNT_W'(1);
    case (st_r)
      SPI_CMD: begin
        if (cmd_last) begin
          st_nxt      = cmd_now[CMD_BITS-1] ? SPI_WAIT : SPI_DATA;
          bit_cnt_nxt = '0;
        end
      end
      SPI_WAIT: begin
        if (wait_last) begin
          st_nxt      = SPI_DATA;
          bit_cnt_nxt = '0;
        end
      end
      SPI_DATA: begin
        if (data_last) begin
          st_nxt      = SPI_DONE;
          bit_cnt_nxt = '0;
        end
      end
      default: begin
        bit_cnt_nxt = '0;
      end
    endcase
  end

  // the frame select ends every frame, the spi clock may stop after it
  always_ff @(posedge spi_sck or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      st_r      <= SPI_CMD;
      bit_cnt_r <= '0;
      sh_in_r   <= '0;
      cmd_r     <= '0;
    end else begin
      st_r      <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sh_in_r   <= {sh_in_r[WORD_W-2:0], spi_mosi};
      if (cmd_last) begin
        cmd_r <= cmd_now;
      end
    end
  end

  // request word stays put while its toggle crosses to the core clock
  always_ff @(posedge spi_sck or posedge rst_link_r) begin
    if (rst_link_r) begin
      req_tgl_r  <= 1'b0;
      req_hold_r <= '0;
    end else if (rd_fire) begin
      req_tgl_r  <= ~req_tgl_r;
      req_hold_r <= '{rd: 1'b1, addr: cmd_now[ADDR_W-1:0], data: '0};
    end else if (wr_fire) begin
      req_tgl_r  <= ~req_tgl_r;
      req_hold_r <= '{rd: 1'b0, addr: cmd_r[ADDR_W-1:0], data: wr_word};
    end
  end

  // the dummy byte gives the core clock time to settle the read word
  always_ff @(negedge spi_sck or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      sh_out_r <= '0;
    end else if (rd_load) begin
      sh_out_r <= cmd_is_fifo ? {rd_word_r[BYTE_W-1:0], {BYTE_W{1'b0}}}
                              : rd_word_r;
    end else begin
      sh_out_r <= {sh_out_r[WORD_W-2:0], 1'b0};
    end
  end

  assign spi_miso_out  = sh_out_r[WORD_W-1];
  assign spi_miso_oe_n = spi_ss_n;

  // ---------------- core side ----------------
  logic              req_s1_r;
  logic              req_s2_r;
  logic              req_s3_r;
  logic [WORD_W-1:0] thr_r;
  logic [WORD_W-1:0] opt_r;
  logic [WORD_W-1:0] sync_top_r;
  logic [WORD_W-1:0] sync_sh_r;
  logic [BYTE_W-1:0] mem_r [1 << PTR_W];
  logic [PTR_W-1:0]  wr_ptr_r;
  logic [PTR_W-1:0]  rd_ptr_r;
  logic              fifo_flag_r;
  logic              packet_event_flag_r;
  logic              pattern_r;
  logic              sync_start_r;
  logic              term_r;
  logic              ack_r;
  logic              idle_r;
  logic              fifo_pin_r;
  logic              pkt_pin_r;
  logic [3:0]        retry_r;
  logic              stg_valid;
  logic              stg_ready;
  logic [BYTE_W-1:0] stg_data;

  always_ff @(posedge clk) begin
    rst_link_r <= rst;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  thr_cfg_t thr_q;
  opt_cfg_t opt_q;
  assign thr_q = thr_cfg_t'(thr_r);
  assign opt_q = opt_cfg_t'(opt_r);

  wire          evt      = req_s2_r ^ req_s3_r;
  wire          h_rd     = evt & req_hold_r.rd;
  wire          h_wr     = evt & ~req_hold_r.rd;
  wire [ADDR_W-1:0] h_addr = req_hold_r.addr;
  wire [WORD_W-1:0] h_data = req_hold_r.data;
  wire          tx_on    = eng_stat.tx_active;
  wire          rx_on    = eng_stat.rx_active;
  wire [PTR_W-1:0] occ   = wr_ptr_r - rd_ptr_r;
  wire          empty    = (occ == '0);
  wire          full     = (occ == {PTR_W{1'b1}});
  wire          host_push = h_wr & (h_addr == ADDR_FIFO) & ~full;
  wire          host_pop  = h_rd & (h_addr == ADDR_FIFO) & ~empty;
  wire          clr_wr   = h_wr & (h_addr == ADDR_PTR) &
                           h_data[PTR_CLR_WR] & ~rx_on;
  wire          clr_rd   = h_wr & (h_addr == ADDR_PTR) &
                           h_data[PTR_CLR_RD] & ~tx_on;
  wire          drain    = stg_valid & rx_on & ~full & ~host_push;
  wire          eng_pop  = tx_byte_valid & tx_byte_ready;
  wire          push     = host_push | drain;
  wire          pop      = host_pop | eng_pop;
  wire [BYTE_W-1:0] push_data = host_push ? h_data[BYTE_W-1:0] : stg_data;

  assign stg_ready     = drain;
  assign tx_byte_valid = tx_on & ~empty & ~host_pop;
  assign tx_byte       = mem_r[rd_ptr_r];

  // occupancy against thresholds, direction picks which one applies
  wire flag_tx   = tx_on & (occ <= {1'b0, thr_q.empty_thr});
  wire flag_rx   = rx_on & (occ >= {1'b0, thr_q.full_thr});
  wire [SERR_W:0] err_p1 = {1'b0, eng_stat.sync_errors} + (SERR_W+1)'(1);
  wire sync_ok   = eng_stat.sync_candidate & rx_on &
                   (err_p1 <= (SERR_W+1)'(thr_q.sync_tol));

  function automatic logic [WORD_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a
  );
    case (a)
      ADDR_SYNC_TOP: read_mux = sync_top_r;
      ADDR_THR:      read_mux = thr_r;
      ADDR_OPT:      read_mux = opt_r;
      ADDR_STAT:     read_mux = {eng_stat.crc_error,
                                 eng_stat.code_correction_fail,
                                 eng_stat.framer_state, pattern_r,
                                 packet_event_flag_r, fifo_flag_r, 5'h00};
      ADDR_FIFO:     read_mux = {8'h00, mem_r[rd_ptr_r]};
      ADDR_PTR:      read_mux = {2'h0, wr_ptr_r, 2'h0, rd_ptr_r};
      default:       read_mux = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      thr_r      <= THR_RST;
      opt_r      <= OPT_RST;
      sync_top_r <= SYNC_TOP_RST;
      rd_word_r  <= '0;
    end else begin
      if (h_wr && h_addr == ADDR_THR) begin
        thr_r <= h_data;
      end
      if (h_wr && h_addr == ADDR_OPT) begin
        opt_r <= h_data;
      end
      if (h_wr && h_addr == ADDR_SYNC_TOP) begin
        sync_top_r <= h_data;
      end
      if (h_rd) begin
        rd_word_r <= read_mux(h_addr);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= push_data;
    end
  end

  // a clear beats a same-cycle move of that index; indexes wrap at 64
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= clr_wr ? '0 : wr_ptr_r + PTR_W'(push);
      rd_ptr_r <= clr_rd ? '0 : rd_ptr_r + PTR_W'(pop);
    end
  end

  // sync word leaves least significant bit first
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_sh_r <= '0;
    end else if (sync_load) begin
      sync_sh_r <= sync_top_r;
    end else if (sync_advance) begin
      sync_sh_r <= {1'b0, sync_sh_r[WORD_W-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_flag_r  <= 1'b0;
      packet_event_flag_r   <= 1'b0;
      pattern_r    <= 1'b0;
      sync_start_r <= 1'b0;
      term_r       <= 1'b0;
      ack_r        <= 1'b0;
      idle_r       <= 1'b0;
      fifo_pin_r   <= 1'b0;
      pkt_pin_r    <= 1'b0;
      retry_r      <= RETRY_DEFAULT;
    end else begin
      fifo_flag_r  <= flag_tx | flag_rx;
      packet_event_flag_r   <= eng_stat.packet_event;
      sync_start_r <= sync_ok;
      pattern_r    <= rx_on & (pattern_r | sync_ok);
      term_r       <= opt_q.auto_tx_termination & tx_on &
                      (wr_ptr_r == rd_ptr_r);
      ack_r        <= eng_stat.rx_pkt_ok & opt_q.auto_ack;
      idle_r       <= eng_stat.rx_pkt_ok & ~opt_q.auto_ack;
      fifo_pin_r   <= fifo_flag_r ^ opt_q.flag_output_polarity;
      pkt_pin_r    <= packet_event_flag_r ^ opt_q.flag_output_polarity;
      retry_r      <= RETRY_LIMIT;
    end
  end

  // staging fifo absorbs engine bursts while the host holds the buffer
  fifo_buf #(
    .W (BYTE_W),
    .D (STG_DEPTH)
  ) u_stage (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_byte_valid),
    .in_ready  (rx_byte_ready),
    .in_data   (rx_byte),
    .out_valid (stg_valid),
    .out_ready (stg_ready),
    .out_data  (stg_data)
  );

  // crc, scramble, length byte and seed go to the engine as settings
  assign thr_cfg          = thr_q;
  // whitening seed lives with the earlier settings, not in this block
  assign opt_cfg          = opt_q;
  assign sync_word_top    = sync_top_r;
  assign sync_tx_bit      = sync_sh_r[0];
  assign rx_sync_start    = sync_start_r;
  assign pattern_detected = pattern_r;
  assign tx_terminate     = term_r;
  assign ack_request      = ack_r;
  assign idle_request     = idle_r;
  assign retry_limit      = retry_r;
  assign packet_flag_pin  = pkt_pin_r;
  assign fifo_flag_pin    = fifo_pin_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_wr_clear_zero: assert property (clr_wr |=> wr_ptr_r == '0)
    else $error("write index not cleared");
  chk_rd_clear_zero: assert property (clr_rd |=> rd_ptr_r == '0)
    else $error("read index not cleared");
  chk_wr_clear_rx: assert property (
    h_wr && h_addr == ADDR_PTR && rx_on && !push |=> $stable(wr_ptr_r))
    else $error("write index cleared in receive");
  chk_tx_almost_empty: assert property (flag_tx |=> fifo_flag_r ##1
    (fifo_pin_r != opt_q.flag_output_polarity) || $changed(opt_r))
    else $error("almost-empty flag missing");
  chk_rx_almost_full: assert property (
    rx_on && occ >= {1'b0, thr_q.full_thr} |=> fifo_flag_r)
    else $error("almost-full flag missing");
  chk_sync_tolerance: assert property (
    sync_ok |=> rx_sync_start && (pattern_detected || !rx_on))
    else $error("sync start not raised");
  chk_pattern_leave: assert property (!rx_on |=> !pattern_r)
    else $error("pattern flag held outside receive");
  chk_flag_polarity: assert property (
    ##1 packet_flag_pin ==
      ($past(packet_event_flag_r) ^ $past(opt_q.flag_output_polarity)))
    else $error("packet flag polarity wrong");
  chk_auto_term: assert property (
    tx_on && opt_q.auto_tx_termination && empty |=> tx_terminate)
    else $error("auto termination missing");
  chk_auto_ack: assert property (
    eng_stat.rx_pkt_ok |=> ack_request != idle_request)
    else $error("ack and idle both or neither");
  chk_pop_step: assert property (host_pop && !clr_rd |=>
    rd_ptr_r == $past(rd_ptr_r) + PTR_W'(1))
    else $error("host read did not pop");
  chk_push_step: assert property (host_push && !clr_wr |=>
    wr_ptr_r == $past(wr_ptr_r) + PTR_W'(1))
    else $error("host write did not push");

  cov_host_push: cover property (host_push ##[1:40] host_pop);
  cov_tx_term: cover property (tx_on ##1 tx_terminate);
  cov_sync_hit: cover property (sync_ok ##1 pattern_detected);
  cov_stage_full: cover property (!rx_byte_ready);
endmodule

// ---- dv/spi_host_model.sv ----
// host microcontroller model: spi master for the register interface
`timescale 1ns/1ps
module spi_host_model (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  logic last_r;
  logic line;

  // a released line shows the inverse of its last value, never a hold
  always @(miso_out or miso_oe_n) begin
    if (!miso_oe_n) last_r = miso_out;
  end
  assign line = miso_oe_n ? ~last_r : miso_out;

  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    last_r = 1'b0;
  end

  // sck runs only inside a frame, 48 ns period, mode 0
  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [15:0] wd, input int nb,
                      output logic [15:0] rdat);
    logic [31:0] sh;
    int          n;
    int          i;
    n = rd ? 16 + nb : 8 + nb;
    sh = rd ? {rd, addr, 24'h0} : {rd, addr, wd << (16 - nb), 8'h0};
    rdat = '0;
    ss_n = 1'b0;
    for (i = 0; i < n; i++) begin
      mosi = sh[31-i];
      #24 sck = 1'b1;
      if (i >= n - nb) rdat[n-1-i] = line;
      #24 sck = 1'b0;
    end
    #24 ss_n = 1'b1;
    mosi = ~mosi;
    // frames stay well apart so the core has applied the access
    #250;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the framer registers, buffer and flags
`timescale 1ns/1ps
module tb_top;
  import framer_pkg::*;
  logic        clk, rst, spi_sck, spi_ss_n, spi_mosi;
  logic        spi_miso_out, spi_miso_oe_n, sync_load, sync_advance;
  logic        sync_tx_bit, rx_sync_start, pattern_detected;
  logic        tx_terminate, ack_request, idle_request;
  logic        rx_byte_valid, rx_byte_ready, tx_byte_valid, tx_byte_ready;
  logic        packet_flag_pin, fifo_flag_pin, acc;
  logic [3:0]  retry_limit;
  logic [7:0]  rx_byte, tx_byte, b;
  logic [15:0] sync_word_top, v, d;
  eng_stat_t   eng_stat;
  thr_cfg_t    thr_cfg;
  opt_cfg_t    opt_cfg;
  int          mismatches, checked, seed, na, ni, ns, n, i, k;
  logic [7:0]  q[$];

  radio_framer_fifo_ctrl #(.RETRY_LIMIT(4'h3), .STG_DEPTH(8)) i_dut (.*);
  spi_host_model i_host (.sck(spi_sck), .ss_n(spi_ss_n), .mosi(spi_mosi),
    .miso_out(spi_miso_out), .miso_oe_n(spi_miso_oe_n));

  always #25 clk = ~clk;

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] wd);
    logic [15:0] junk;
    i_host.xfer(1'b0, a, wd, (a == ADDR_FIFO) ? 8 : 16, junk);
    @(negedge clk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] rv);
    i_host.xfer(1'b1, a, 16'h0000, (a == ADDR_FIFO) ? 8 : 16, rv);
    @(negedge clk);
  endtask

  function automatic logic [15:0] idx(input int w, input int r);
    return {2'b00, 6'(w), 2'b00, 6'(r)};
  endfunction

  // one engine event, then count the pulses that answer it
  task automatic strobe(input logic ok, input logic cand, input int se);
    @(negedge clk);
    eng_stat.rx_pkt_ok = ok;
    eng_stat.sync_candidate = cand;
    eng_stat.sync_errors = 7'(se);
    na = 0;
    ni = 0;
    ns = 0;
    repeat (4) begin
      @(negedge clk);
      eng_stat.rx_pkt_ok = 1'b0;
      eng_stat.sync_candidate = 1'b0;
      na += ack_request;
      ni += idle_request;
      ns += rx_sync_start;
    end
  endtask

  task automatic pull(output logic [7:0] pb);
    @(negedge clk);
    tx_byte_ready = 1'b1;
    pb = (tx_byte_valid === 1'b1) ? tx_byte : 8'hxx;
    @(negedge clk);
    tx_byte_ready = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is about two hundred microseconds
  initial begin
    #1_000_000;
    mismatches++;
    end_sim();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    seed = 32'hE5271E8E;
    eng_stat = '0;
    {sync_load, sync_advance, rx_byte_valid, tx_byte_ready} = '0;
    rx_byte = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(ADDR_THR, d);
    cmp(d, THR_RST, "thr rst");
    rd(ADDR_OPT, d);
    cmp(d, OPT_RST, "opt rst");
    rd(ADDR_SYNC_TOP, d);
    cmp(d, SYNC_TOP_RST, "sync rst");
    cmp(16'(retry_limit), 16'(RETRY_DEFAULT), "retry");
    cmp(16'(spi_miso_oe_n), 16'h0001, "miso released");
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      wr(ADDR_SYNC_TOP, v);
      cmp(sync_word_top, v, "sync port");
      @(negedge clk);
      sync_load = 1'b1;
      @(negedge clk);
      sync_load = 1'b0;
      for (i = 0; i < 16; i++) begin
        cmp(16'(sync_tx_bit), 16'(v[i]), "sync bit");
        sync_advance = 1'b1;
        @(negedge clk);
        sync_advance = 1'b0;
        @(negedge clk);
      end
      v = $random(seed);
      wr(ADDR_THR, v);
      rd(ADDR_THR, d);
      cmp(d, v, "thr rw");
      cmp(thr_cfg, v, "thr port");
      eng_stat.rx_active = 1'b1;
      strobe(1'b0, 1'b1, v[5:0]);
      cmp(16'(ns), 16'h0000, "sync reject");
      strobe(1'b0, 1'b1, (v[5:0] == 0) ? 0 : v[5:0] - 1);
      cmp(16'(ns), 16'(v[5:0] != 0), "sync accept");
      cmp(16'(pattern_detected), 16'(v[5:0] != 0), "pat set");
      eng_stat.rx_active = 1'b0;
      repeat (3) @(negedge clk);
      cmp(16'(pattern_detected), 16'h0000, "pat clr");
      v = $random(seed);
      wr(ADDR_OPT, v);
      rd(ADDR_OPT, d);
      cmp(d, v, "opt rw");
      cmp(opt_cfg, v, "opt port");
      {eng_stat.crc_error, eng_stat.code_correction_fail,
       eng_stat.framer_state, eng_stat.packet_event} = $random(seed);
      repeat (3) @(negedge clk);
      cmp(16'(packet_flag_pin), 16'(eng_stat.packet_event ^ v[10]),
          "pkt pin");
      cmp(16'(fifo_flag_pin), 16'(v[10]), "fifo pin");
      strobe(1'b1, 1'b0, 0);
      cmp(16'(na), 16'(v[11]), "ack");
      cmp(16'(ni), 16'(!v[11]), "idle");
      wr(ADDR_STAT, 16'hFFFF);
      rd(ADDR_STAT, d);
      cmp(d, {eng_stat.crc_error, eng_stat.code_correction_fail,
          eng_stat.framer_state, 1'b0, eng_stat.packet_event, 6'h00},
          "status");
      wr(7'h31, 16'hFFFF);
      rd(7'h31, d);
      cmp(d, 16'h0000, "unmapped");
    end
    eng_stat = '0;
    wr(ADDR_THR, THR_RST);
    wr(ADDR_OPT, OPT_RST);
    $display("test config done");
    eng_stat.rx_active = 1'b1;
    rx_byte_valid = 1'b1;
    rx_byte = $random(seed);
    for (i = 0; i < 100; i++) begin
      acc = (rx_byte_ready === 1'b1);
      @(negedge clk);
      if (acc) q.push_back(rx_byte);
      if (acc) rx_byte = $random(seed);
    end
    cmp(16'(rx_byte_ready), 16'h0000, "refuse");
    rx_byte_valid = 1'b0;
    n = q.size();
    rd(ADDR_PTR, d);
    cmp(d, idx(63, 0), "full idx");
    cmp(16'(fifo_flag_pin), 16'h0001, "almost full");
    while (q.size() > 0) begin
      rd(ADDR_FIFO, d);
      cmp(d, {8'h00, q.pop_front()}, "pop");
    end
    rd(ADDR_PTR, d);
    cmp(d, idx(n, n), "drain idx");
    cmp(16'(fifo_flag_pin), 16'h0000, "not full");
    wr(ADDR_PTR, 16'h8000);
    rd(ADDR_PTR, d);
    cmp(d, idx(n, n), "wclr rx");
    eng_stat.rx_active = 1'b0;
    eng_stat.tx_active = 1'b1;
    wr(ADDR_PTR, 16'h0080);
    rd(ADDR_PTR, d);
    cmp(d, idx(n, n), "rclr tx");
    wr(ADDR_PTR, 16'h8000);
    rd(ADDR_PTR, d);
    cmp(d, idx(0, n), "wclr tx");
    eng_stat.tx_active = 1'b0;
    wr(ADDR_PTR, 16'h8080);
    rd(ADDR_PTR, d);
    cmp(d, idx(0, 0), "clr idle");
    $display("test rx done");
    for (i = 0; i < 5; i++) begin
      q.push_back(8'($random(seed)));
      wr(ADDR_FIFO, {8'h00, q[i]});
    end
    rd(ADDR_PTR, d);
    cmp(d, idx(5, 0), "push idx");
    eng_stat.tx_active = 1'b1;
    repeat (4) @(negedge clk);
    cmp(16'(fifo_flag_pin), 16'h0000, "above empty");
    for (i = 0; i < 5; i++) begin
      pull(b);
      cmp(16'(b), 16'(q[i]), "tx byte");
      cmp(16'(fifo_flag_pin), 16'h0001, "almost empty");
      cmp(16'(tx_terminate), 16'(i == 4), "term");
    end
    eng_stat.tx_active = 1'b0;
    $display("test tx done");
    end_sim();
  end
endmodule
